// *** src/apf_pkg.sv ***
// Shared constants and types for the auxiliary pin function selector.
// Assumes one 40 MHz system clock; all users reference items as apf_pkg::name.
package apf_pkg;
   localparam int NPINS = 10;
   localparam int SEL_W = 4;

   // Pin function options as held in configuration memory
   typedef enum logic [3:0] {
      OPT_INPUT_PULLED_UP,
      OPT_LINE_DRIVER_ENABLE,
      OPT_POWER_SWITCH_ENABLE,
      OPT_TX_ACTIVITY_LED,
      OPT_RX_ACTIVITY_LED,
      OPT_TXRX_ACTIVITY_LED,
      OPT_SUSPEND_INDICATOR,
      OPT_CLOCK_OUT_THIRTY,
      OPT_CLOCK_OUT_FIFTEEN,
      OPT_CLOCK_OUT_SEVEN_HALF,
      OPT_DRIVE_HIGH,
      OPT_DRIVE_LOW,
      OPT_BIT_BANG
   } apf_opt_e;

   // Pins on which each option group may be selected
   localparam logic [9:0] PINS_GENERAL = 10'h37F;
   localparam logic [9:0] PINS_CLOCK = 10'h361;
   localparam logic [9:0] PINS_BIT_BANG = 10'h360;
   localparam int PULLDOWN_PIN = 7;

   // Clock rates in units of 0.1 MHz; SYS_CLK_MHZ in MHz
   localparam int unsigned SYS_CLK_DMHZ = 400;
   localparam int unsigned SYS_CLK_MHZ = 40;
   localparam int unsigned CLK_OUT_DMHZ [3] = '{300, 150, 75};
   localparam int NCO_W = 10;

   // Activity LED low pulse, least time
   localparam int unsigned LED_PULSE_US = 10;
   localparam int unsigned LED_PULSE_CYC = LED_PULSE_US * SYS_CLK_MHZ;
   localparam int LED_CNT_W = $clog2(LED_PULSE_CYC + 1);

   // AXI4-Lite register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SEL_LO = 8'h08;
   localparam logic [7:0] ADDR_SEL_HI = 8'h0C;
   localparam logic [31:0] CTRL_MASK = 32'h03FF03FF;
   localparam int CTRL_OE_LSB = 16;
   localparam int ST_SUSPEND = 16;
   localparam int ST_CONFIGURED = 17;
   localparam int ST_CFG_PRESENT = 18;
   localparam int ST_UART_MODE = 19;
   localparam int ST_LINE_DRV = 20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** src/apf_pin_mux.sv ***
// One configurable auxiliary pin: picks its drive, enable and pulls from the option.
// Assumes all function inputs come from logic on the same clock.
module apf_pin_mux #(
   parameter int PIN = 0
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] sel_i,
   input wire logic line_drv_i,
   input wire logic pwr_n_i,
   input wire logic tx_activity_led_n_n_i,
   input wire logic rx_activity_led_n_n_i,
   input wire logic txrxled_n_i,
   input wire logic sleep_n_i,
   input wire logic [2:0] clk_i,
   input wire logic bb_out_i,
   input wire logic bb_oe_i,
   input wire logic suspend_i,
   input wire logic susp_pd_i,
   output logic out_o,
   output logic oe_o,
   output logic pu_o,
   output logic pd_o
);
   logic out_nxt;
   logic oe_nxt;
   logic in_mode;

   always_comb begin
      out_nxt = 1'b0;
      oe_nxt = 1'b1;
      case (apf_pkg::apf_opt_e'(sel_i))
         apf_pkg::OPT_LINE_DRIVER_ENABLE: out_nxt = line_drv_i;
         apf_pkg::OPT_POWER_SWITCH_ENABLE: out_nxt = pwr_n_i;
         apf_pkg::OPT_TX_ACTIVITY_LED: out_nxt = tx_activity_led_n_n_i;
         apf_pkg::OPT_RX_ACTIVITY_LED: out_nxt = rx_activity_led_n_n_i;
         apf_pkg::OPT_TXRX_ACTIVITY_LED: out_nxt = txrxled_n_i;
         apf_pkg::OPT_SUSPEND_INDICATOR: out_nxt = sleep_n_i;
         apf_pkg::OPT_CLOCK_OUT_THIRTY: out_nxt = clk_i[0];
         apf_pkg::OPT_CLOCK_OUT_FIFTEEN: out_nxt = clk_i[1];
         apf_pkg::OPT_CLOCK_OUT_SEVEN_HALF: out_nxt = clk_i[2];
         apf_pkg::OPT_DRIVE_HIGH: out_nxt = 1'b1;
         apf_pkg::OPT_DRIVE_LOW: out_nxt = 1'b0;
         apf_pkg::OPT_BIT_BANG: begin
            out_nxt = bb_out_i;
            oe_nxt = bb_oe_i;
         end
         default: oe_nxt = 1'b0;
      endcase
      // Options outside a pin's allowed set fall back to a pulled input
      if (apf_pkg::apf_opt_e'(sel_i) inside {apf_pkg::OPT_CLOCK_OUT_THIRTY,
            apf_pkg::OPT_CLOCK_OUT_FIFTEEN, apf_pkg::OPT_CLOCK_OUT_SEVEN_HALF,
            apf_pkg::OPT_DRIVE_HIGH} && !apf_pkg::PINS_CLOCK[PIN]) begin
         oe_nxt = 1'b0;
      end
      if (apf_pkg::apf_opt_e'(sel_i) == apf_pkg::OPT_BIT_BANG
            && !apf_pkg::PINS_BIT_BANG[PIN]) begin
         oe_nxt = 1'b0;
      end
      if (!apf_pkg::PINS_GENERAL[PIN]) begin
         oe_nxt = 1'b0;
      end
      if (!oe_nxt) begin
         out_nxt = 1'b0;
      end
      in_mode = !oe_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_o <= 1'b0;
         oe_o <= 1'b0;
         pu_o <= 1'b0;
         pd_o <= 1'b0;
      end else begin
         out_o <= out_nxt;
         oe_o <= oe_nxt;
         // Pin 7 input pulls down; others pull up, or down in suspend if asked
         pd_o <= in_mode && (PIN == apf_pkg::PULLDOWN_PIN
                 || (susp_pd_i && suspend_i));
         pu_o <= in_mode && !(PIN == apf_pkg::PULLDOWN_PIN
                 || (susp_pd_i && suspend_i));
      end
   end
endmodule // apf_pin_mux

// *** src/apf_top.sv ***
// Auxiliary pin function selector with serial port pin roles and AXI4-Lite registers.
// Assumes the UART engine, USB core and config loader run on sys_clk_i; pins are async.

// Overview of operation
// - A selected line driver enable rises one bit time before the start bit and falls after the stop bit.
// - A selected power switch enable goes low once USB is configured and high during suspend.
// - A selected transmit activity output pulses low while serial data is sent.
// - A selected receive activity output pulses low while serial data is received.
// - A selected combined activity output pulses low on either transmit or receive.
// - A selected suspend indicator is low during USB suspend and high otherwise.
// - Clock outputs of 15 and 7.5 MHz are offered, the 30 MHz option giving 20 MHz (half the system clock); all stop during suspend.
// - Each pin function except pin 7's is taken from configuration memory when that memory is present.
// - Without configuration memory every pin is a pulled-up input, pin 7 a pulled-down input.
// - Serial port mode is the default mode unless configuration picks another.
// - In serial mode transmit data and request-to-send are outputs, receive data and clear-to-send inputs.
// - In serial mode terminal-ready is an output and set-ready, carrier and ring are sampled inputs.
// - With remote wakeup enabled, ring driven low during suspend makes the device request resume.
module apf_top (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic cfg_load_i,
   input wire logic cfg_present_i,
   input wire logic [39:0] cfg_pin_sel_i,
   input wire logic cfg_uart_mode_i,
   input wire logic cfg_wake_en_i,
   input wire logic cfg_susp_pd_i,
   input wire logic usb_configured_i,
   input wire logic usb_suspend_i,
   output logic resume_req_o,
   input wire logic eng_txd_i,
   input wire logic eng_rts_n_i,
   input wire logic eng_dtr_n_i,
   input wire logic eng_tx_req_i,
   input wire logic eng_bit_tick_i,
   input wire logic eng_tx_done_i,
   input wire logic eng_tx_byte_i,
   input wire logic eng_rx_byte_i,
   output logic eng_tx_start_o,
   output logic eng_rxd_o,
   output logic eng_cts_n_o,
   output logic eng_dsr_n_o,
   output logic eng_dcd_n_o,
   output logic eng_ri_n_o,
   output logic txd_o,
   output logic txd_oe_o,
   output logic rts_n_o,
   output logic rts_oe_o,
   output logic dtr_n_o,
   output logic dtr_oe_o,
   input wire logic rxd_i,
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic dcd_n_i,
   input wire logic ri_n_i,
   input wire logic [9:0] aux_config_pins_i,
   output logic [9:0] aux_config_pins_o,
   output logic [9:0] aux_config_pins_oe_o,
   output logic [9:0] aux_pu_o,
   output logic [9:0] aux_pd_o
);
   typedef enum {LD_IDLE, LD_LEAD, LD_FRAME} apf_ld_state_e;

   localparam logic [39:0] SEL_DEFAULT = {apf_pkg::NPINS{apf_pkg::OPT_INPUT_PULLED_UP}};

   // Configuration
   logic [39:0] sel_r;
   logic uart_mode_r;
   logic wake_en_r;
   logic susp_pd_r;
   logic cfg_present_r;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_r <= SEL_DEFAULT;
         uart_mode_r <= 1'b1;
         wake_en_r <= 1'b0;
         susp_pd_r <= 1'b0;
         cfg_present_r <= 1'b0;
      end else if (cfg_load_i) begin
         cfg_present_r <= cfg_present_i;
         if (cfg_present_i) begin
            sel_r <= cfg_pin_sel_i;
            uart_mode_r <= cfg_uart_mode_i;
            wake_en_r <= cfg_wake_en_i;
            susp_pd_r <= cfg_susp_pd_i;
         end else begin
            sel_r <= SEL_DEFAULT;
            uart_mode_r <= 1'b1;
            wake_en_r <= 1'b0;
            susp_pd_r <= 1'b0;
         end
      end
   end

   // Pin synchronisers: only the second stage is read
   logic [4:0] ser_s1_r;
   logic [4:0] ser_s2_r;
   logic [9:0] aux_s1_r;
   logic [9:0] aux_s2_r;
   logic ri_prev_r;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ser_s1_r <= 5'h1F;
         ser_s2_r <= 5'h1F;
         aux_s1_r <= 10'h000;
         aux_s2_r <= 10'h000;
         ri_prev_r <= 1'b1;
      end else begin
         ser_s1_r <= {ri_n_i, dcd_n_i, dsr_n_i, cts_n_i, rxd_i};
         ser_s2_r <= ser_s1_r;
         aux_s1_r <= aux_config_pins_i;
         aux_s2_r <= aux_s1_r;
         ri_prev_r <= ser_s2_r[4];
      end
   end

   assign eng_rxd_o = ser_s2_r[0];
   assign eng_cts_n_o = ser_s2_r[1];
   assign eng_dsr_n_o = ser_s2_r[2];
   assign eng_dcd_n_o = ser_s2_r[3];
   assign eng_ri_n_o = ser_s2_r[4];

   // Serial outputs; released when another mode is configured
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         txd_o <= 1'b1;
         rts_n_o <= 1'b1;
         dtr_n_o <= 1'b1;
         txd_oe_o <= 1'b0;
         rts_oe_o <= 1'b0;
         dtr_oe_o <= 1'b0;
      end else begin
         txd_o <= eng_txd_i;
         rts_n_o <= eng_rts_n_i;
         dtr_n_o <= eng_dtr_n_i;
         txd_oe_o <= uart_mode_r;
         rts_oe_o <= uart_mode_r;
         dtr_oe_o <= uart_mode_r;
      end
   end

   // Remote wakeup: falling ring edge while suspended
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         resume_req_o <= 1'b0;
      end else begin
         resume_req_o <= wake_en_r && usb_suspend_i && ri_prev_r && !ser_s2_r[4];
      end
   end

   // Line driver enable: lead the start bit by one bit tick only when a pin uses it
   apf_ld_state_e ld_state_r;
   logic line_drv_r;
   logic ld_used;

   always_comb begin
      ld_used = 1'b0;
      for (int p = 0; p < apf_pkg::NPINS; p++) begin
         if (sel_r[p*apf_pkg::SEL_W +: apf_pkg::SEL_W] == apf_pkg::OPT_LINE_DRIVER_ENABLE
               && apf_pkg::PINS_GENERAL[p]) begin
            ld_used = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ld_state_r <= LD_IDLE;
         line_drv_r <= 1'b0;
         eng_tx_start_o <= 1'b0;
      end else begin
         eng_tx_start_o <= 1'b0;
         case (ld_state_r)
            LD_IDLE: begin
               if (eng_tx_req_i && ld_used) begin
                  line_drv_r <= 1'b1;
                  ld_state_r <= LD_LEAD;
               end else if (eng_tx_req_i) begin
                  eng_tx_start_o <= 1'b1;
                  ld_state_r <= LD_FRAME;
               end
            end
            LD_LEAD: begin
               if (eng_bit_tick_i) begin
                  eng_tx_start_o <= 1'b1;
                  ld_state_r <= LD_FRAME;
               end
            end
            LD_FRAME: begin
               if (eng_tx_done_i) begin
                  line_drv_r <= 1'b0;
                  ld_state_r <= LD_IDLE;
               end
            end
            default: begin
               line_drv_r <= 1'b0;
               ld_state_r <= LD_IDLE;
            end
         endcase
      end
   end

   // Activity LED stretchers; retrigger on every byte
   logic [apf_pkg::LED_CNT_W-1:0] tx_led_cnt_r;
   logic [apf_pkg::LED_CNT_W-1:0] rx_led_cnt_r;
   localparam logic [apf_pkg::LED_CNT_W-1:0] LED_LOAD = apf_pkg::LED_CNT_W'(apf_pkg::LED_PULSE_CYC);

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_led_cnt_r <= '0;
         rx_led_cnt_r <= '0;
      end else begin
         if (eng_tx_byte_i) begin
            tx_led_cnt_r <= LED_LOAD;
         end else if (tx_led_cnt_r != '0) begin
            tx_led_cnt_r <= tx_led_cnt_r - 1'b1;
         end
         if (eng_rx_byte_i) begin
            rx_led_cnt_r <= LED_LOAD;
         end else if (rx_led_cnt_r != '0) begin
            rx_led_cnt_r <= rx_led_cnt_r - 1'b1;
         end
      end
   end

   // Clock outputs: rate accumulators, capped at half the system clock; held low in suspend
   logic [2:0] clk_out_r;

   for (genvar c = 0; c < 3; c++) begin : g_clk
      localparam logic [apf_pkg::NCO_W-1:0] STEP = apf_pkg::NCO_W'(2 * apf_pkg::CLK_OUT_DMHZ[c]);
      localparam logic [apf_pkg::NCO_W-1:0] MODU = apf_pkg::NCO_W'(apf_pkg::SYS_CLK_DMHZ);
      logic [apf_pkg::NCO_W-1:0] acc_r;
      logic [apf_pkg::NCO_W-1:0] sum;
      assign sum = acc_r + STEP;
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            acc_r <= '0;
            clk_out_r[c] <= 1'b0;
         end else if (usb_suspend_i) begin
            acc_r <= '0;
            clk_out_r[c] <= 1'b0;
         end else if (sum >= MODU) begin
            acc_r <= (sum - MODU >= MODU) ? '0 : sum - MODU;
            clk_out_r[c] <= !clk_out_r[c];
         end else begin
            acc_r <= sum;
         end
      end
   end

   // Register file
   logic [31:0] ctrl_r;
   logic [7:0] awaddr_r;
   logic aw_got_r;
   logic w_got_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= apf_pkg::RESP_OKAY;
         ctrl_r <= '0;
      end else begin
         if (s_axi_awready_o && s_axi_awvalid_i) begin
            awaddr_r <= s_axi_awaddr_i;
            aw_got_r <= 1'b1;
            s_axi_awready_o <= 1'b0;
         end else if (!aw_got_r && !s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
         end
         if (s_axi_wready_o && s_axi_wvalid_i) begin
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
            w_got_r <= 1'b1;
            s_axi_wready_o <= 1'b0;
         end else if (!w_got_r && !s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
         end
         if (aw_got_r && w_got_r && !s_axi_bvalid_o) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= apf_pkg::RESP_OKAY;
            if (awaddr_r[7:2] == apf_pkg::ADDR_CTRL[7:2]) begin
               for (int b = 0; b < 4; b++) begin
                  if (wstrb_r[b]) begin
                     ctrl_r[b*8 +: 8] <= wdata_r[b*8 +: 8] & apf_pkg::CTRL_MASK[b*8 +: 8];
                  end
               end
            end else if (awaddr_r[7:2] != apf_pkg::ADDR_STATUS[7:2]
                  && awaddr_r[7:2] != apf_pkg::ADDR_SEL_LO[7:2]
                  && awaddr_r[7:2] != apf_pkg::ADDR_SEL_HI[7:2]) begin
               s_axi_bresp_o <= apf_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   logic [31:0] status;
   always_comb begin
      status = '0;
      status[9:0] = aux_s2_r;
      status[apf_pkg::ST_SUSPEND] = usb_suspend_i;
      status[apf_pkg::ST_CONFIGURED] = usb_configured_i;
      status[apf_pkg::ST_CFG_PRESENT] = cfg_present_r;
      status[apf_pkg::ST_UART_MODE] = uart_mode_r;
      status[apf_pkg::ST_LINE_DRV] = line_drv_r;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= apf_pkg::RESP_OKAY;
      end else if (s_axi_arready_o && s_axi_arvalid_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o <= apf_pkg::RESP_OKAY;
         case (s_axi_araddr_i[7:2])
            apf_pkg::ADDR_CTRL[7:2]: s_axi_rdata_o <= ctrl_r;
            apf_pkg::ADDR_STATUS[7:2]: s_axi_rdata_o <= status;
            apf_pkg::ADDR_SEL_LO[7:2]: s_axi_rdata_o <= sel_r[31:0];
            apf_pkg::ADDR_SEL_HI[7:2]: s_axi_rdata_o <= {24'h000000, sel_r[39:32]};
            default: begin
               s_axi_rdata_o <= '0;
               s_axi_rresp_o <= apf_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end else if (!s_axi_rvalid_o) begin
         s_axi_arready_o <= 1'b1;
      end
   end

   // Pin muxes
   logic pwr_n;
   logic sleep_n;
   assign pwr_n = !(usb_configured_i && !usb_suspend_i);
   assign sleep_n = !usb_suspend_i;

   for (genvar p = 0; p < apf_pkg::NPINS; p++) begin : g_pin
      apf_pin_mux #(.PIN(p)) u_mux (
         .sys_clk_i(sys_clk_i),
         .rstn_i(rstn_i),
         .sel_i(sel_r[p*apf_pkg::SEL_W +: apf_pkg::SEL_W]),
         .line_drv_i(line_drv_r),
         .pwr_n_i(pwr_n),
         .tx_activity_led_n_n_i(tx_led_cnt_r == '0),
         .rx_activity_led_n_n_i(rx_led_cnt_r == '0),
         .txrxled_n_i(tx_led_cnt_r == '0 && rx_led_cnt_r == '0),
         .sleep_n_i(sleep_n),
         .clk_i(clk_out_r),
         .bb_out_i(ctrl_r[p]),
         .bb_oe_i(ctrl_r[apf_pkg::CTRL_OE_LSB + p]),
         .suspend_i(usb_suspend_i),
         .susp_pd_i(susp_pd_r),
         .out_o(aux_config_pins_o[p]),
         .oe_o(aux_config_pins_oe_o[p]),
         .pu_o(aux_pu_o[p]),
         .pd_o(aux_pd_o[p])
      );
   end
endmodule // apf_top

// *** tb/apf_partner.sv ***
// Far side of the aux pins and modem lines: pulls and a ringing modem.
// Assumes pin drive, enable and pull controls come straight from the block.
module apf_partner (
   input wire logic sys_clk_i,
   input wire logic ring_i,
   input wire logic [9:0] out_i,
   input wire logic [9:0] oe_i,
   input wire logic [9:0] pu_i,
   input wire logic [9:0] pd_i,
   output logic [9:0] pins_o,
   output logic ri_n_o,
   output logic idle_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic flip_r = 1'h0;
   always_ff @(posedge sys_clk_i) flip_r <= ~flip_r;
   assign pins_o = (oe_i & out_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ~pd_i & {10{flip_r}});
   assign ri_n_o = ~ring_i;
   assign idle_o = 1'h1;
endmodule // apf_partner

// *** tb/apf_monitor.sv ***
// Port checker for the aux pin selector.
// Assumes one clock domain; bound to every apf_top instance.
module apf_monitor (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic eng_tx_req_i,
   input wire logic eng_tx_start_o,
   input wire logic usb_suspend_i,
   input wire logic resume_req_o,
   input wire logic [9:0] aux_config_pins_oe_o,
   input wire logic [9:0] aux_pu_o,
   input wire logic [9:0] aux_pd_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_pin7; $past(rstn_i) |-> aux_pd_o[7] && !aux_pu_o[7] && !aux_config_pins_oe_o[7];
   endproperty
   a_pin7: assert property (p_pin7) else $error("pin 7 not pulled down");
   property p_start; eng_tx_start_o |-> $past(eng_tx_req_i) ##1 !eng_tx_start_o; endproperty
   a_start: assert property (p_start) else $error("start without request");
   property p_resume; resume_req_o |-> $past(usb_suspend_i) ##1 !resume_req_o; endproperty
   a_resume: assert property (p_resume) else $error("resume outside suspend");
   property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o; endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_brise; $rose(s_axi_bvalid_o) |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
   a_brise: assert property (p_brise) else $error("ready during response");
   property p_arready; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
   a_arready: assert property (p_arready) else $error("arready during read data");
   property p_wide; $past(rstn_i) |-> aux_pd_o[7] || aux_pu_o[7] == 1'h0; endproperty
   a_wide: assert property (p_wide) else $error("pin 7 pulled up");
endmodule // apf_monitor

bind apf_top apf_monitor i_apf_monitor (.sys_clk_i, .rstn_i, .s_axi_awready_o,
   .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arready_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .eng_tx_req_i, .eng_tx_start_o, .usb_suspend_i, .resume_req_o,
   .aux_config_pins_oe_o, .aux_pu_o, .aux_pd_o);

// *** tb/apf_top_bench.sv ***
// Self-checking bench for the aux pin selector: AXI4-Lite master, pin partner.
// Assumes the package and design sources compile first.
module apf_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i, rstn_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
   logic s_axi_rready_i, cfg_load_i, cfg_present_i, cfg_uart_mode_i, cfg_wake_en_i;
   logic cfg_susp_pd_i, usb_configured_i, usb_suspend_i, resume_req_o, eng_txd_i, eng_rts_n_i;
   logic eng_dtr_n_i, eng_tx_req_i, eng_bit_tick_i, eng_tx_done_i, eng_tx_byte_i, eng_rx_byte_i;
   logic eng_tx_start_o, eng_rxd_o, eng_cts_n_o, eng_dsr_n_o, eng_dcd_n_o, eng_ri_n_o, txd_o;
   logic txd_oe_o, rts_n_o, rts_oe_o, dtr_n_o, dtr_oe_o, rxd_i, cts_n_i, dsr_n_i, dcd_n_i, ri_n_i;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [39:0] cfg_pin_sel_i;
   logic [9:0] aux_config_pins_i, aux_config_pins_o, aux_config_pins_oe_o, aux_pu_o, aux_pd_o;
   logic [4:0] pl;
   logic ring;
   int errors = 0, checks = 0, seed = 23, n, c;
   logic [1:0] qb[$];
   logic [33:0] qr[$];
   apf_top i_apf_top (.*);
   apf_partner i_apf_partner (.sys_clk_i, .ring_i(ring), .out_i(aux_config_pins_o),
      .oe_i(aux_config_pins_oe_o), .pu_i(aux_pu_o), .pd_i(aux_pd_o),
      .pins_o(aux_config_pins_i), .ri_n_o(ri_n_i), .idle_o(rxd_i));
   assign {cts_n_i, dsr_n_i, dcd_n_i} = {3{rxd_i}};
   assign {cfg_load_i, eng_bit_tick_i, eng_tx_done_i, eng_tx_byte_i, eng_rx_byte_i} = pl;
   initial begin
      sys_clk_i = 1'h0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   task results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic ok);
      checks++;
      if (ok !== 1'h1) begin
         errors++;
         $display("[ERR] %0t mismatch", $time);
      end
   endtask
   task lim(input int k);
      if (k >= 10) begin
         errors++;
         $display("[ERR] %0t timeout", $time);
         results();
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask
   task pulse(input int b);
      pl[b] <= 1'h1;
      @(posedge sys_clk_i);
      pl[b] <= 1'h0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      qb.push_back(r);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
         n++;
      end while (s_axi_bvalid_o !== 1'h1 && n < 10);
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h0;
      lim(n);
   endtask
   task rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] v);
      qr.push_back({r, v});
      s_axi_araddr_i <= a;
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
         n++;
      end while (s_axi_rvalid_o !== 1'h1 && n < 10);
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'h0;
      lim(n);
   endtask
   // Pin 8 toggles seen over 80 cycles
   task togs;
      logic p;
      c = 0;
      p = aux_config_pins_o[8];
      repeat (80) begin
         @(posedge sys_clk_i);
         if (aux_config_pins_o[8] !== p) c++;
         p = aux_config_pins_o[8];
      end
   endtask
   always @(posedge sys_clk_i) begin
      if (s_axi_bvalid_o && s_axi_bready_i) chk(qb.size() != 0 && qb.pop_front() === s_axi_bresp_o);
      if (s_axi_rvalid_o && s_axi_rready_i) chk(qr.size() != 0 && qr.pop_front() === {s_axi_rresp_o, s_axi_rdata_o});
   end
   initial begin
      rstn_i <= 1'h0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} <= 5'h0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {16'h0, 32'h0, 4'hF};
      {pl, ring, eng_tx_req_i, cfg_present_i, cfg_wake_en_i, cfg_susp_pd_i} <= 11'h0;
      {usb_configured_i, usb_suspend_i, cfg_uart_mode_i, cfg_pin_sel_i} <= {3'h1, 40'h0};
      {eng_txd_i, eng_rts_n_i, eng_dtr_n_i} <= 3'h7;
      cyc(10);
      rstn_i <= 1'h1;
      cyc(6);
      chk(aux_pu_o === 10'h37F && aux_pd_o === 10'h080 && aux_config_pins_oe_o === 10'h0);
      chk({txd_oe_o, rts_oe_o, dtr_oe_o} === 3'h7);
      rd(apf_pkg::ADDR_STATUS, apf_pkg::RESP_OKAY, 32'h0008037F);
      rd(8'h10, apf_pkg::RESP_SLVERR, 32'h0);
      wr(8'h10, 32'h1, apf_pkg::RESP_SLVERR);
      wr(apf_pkg::ADDR_STATUS, 32'h1, apf_pkg::RESP_OKAY);
      repeat (4) begin
         d = $random(seed);
         wr(apf_pkg::ADDR_CTRL, d, apf_pkg::RESP_OKAY);
         rd(apf_pkg::ADDR_CTRL, apf_pkg::RESP_OKAY, d & apf_pkg::CTRL_MASK);
      end
      $display("register test done");
      {cfg_present_i, cfg_wake_en_i, cfg_susp_pd_i, usb_configured_i} <= 4'hF;
      cfg_pin_sel_i <= 40'h59BAC64321;
      {eng_txd_i, eng_dtr_n_i} <= 2'h0;
      pulse(4);
      wr(apf_pkg::ADDR_CTRL, 32'h00200020, apf_pkg::RESP_OKAY);
      cyc(4);
      chk(aux_config_pins_o[6] === 1'h1 && aux_config_pins_oe_o[7:5] === 3'h3);
      chk(aux_config_pins_o[5] === 1'h1 && aux_pd_o[7] === 1'h1);
      chk(aux_config_pins_o[1] === 1'h0 && aux_config_pins_o[4] === 1'h1);
      chk({txd_o, dtr_n_o, rts_n_o, eng_dsr_n_o, eng_rxd_o} === 5'h7);
      togs();
      chk(c >= 29 && c <= 31);
      eng_tx_req_i <= 1'h1;
      cyc(4);
      chk(aux_config_pins_o[0] === 1'h1 && aux_config_pins_oe_o[0] === 1'h1);
      pulse(3);
      for (n = 0; eng_tx_start_o !== 1'h1 && n < 10; n++) @(posedge sys_clk_i);
      lim(n);
      eng_tx_req_i <= 1'h0;
      cyc(3);
      chk(aux_config_pins_o[0] === 1'h1);
      pulse(2);
      cyc(4);
      chk(aux_config_pins_o[0] === 1'h0);
      pulse(1);
      cyc(4);
      chk(aux_config_pins_o[3:2] === 2'h2 && aux_config_pins_o[9] === 1'h0);
      cyc(450);
      chk(aux_config_pins_o[2] === 1'h1 && aux_config_pins_o[9] === 1'h1);
      pulse(0);
      cyc(4);
      chk(aux_config_pins_o[3] === 1'h0 && aux_config_pins_o[9] === 1'h0);
      $display("pin function test done");
      usb_suspend_i <= 1'h1;
      cyc(4);
      chk(aux_config_pins_o[1] === 1'h1 && aux_config_pins_o[4] === 1'h0);
      togs();
      chk(c == 0 && aux_config_pins_o[8] === 1'h0);
      ring <= 1'h1;
      for (n = 0; resume_req_o !== 1'h1 && n < 10; n++) @(posedge sys_clk_i);
      lim(n);
      ring <= 1'h0;
      $display("suspend test done");
      results();
   end
endmodule // apf_top_bench
